// ---- rtl/chan_ctrl_end.sv ----
// channel controller: cpu channel instructions and control block engine
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module chan_ctrl_end (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        monitor_mode_in,
   input  wire logic [4:0]  cpu_addr_in,
   input  wire logic [31:0] cpu_wdata_in,
   input  wire logic        cpu_wr_in,
   input  wire logic        cpu_rd_in,
   output logic [31:0]      cpu_rdata_out,
   output logic             cpu_io_interrupt_request_out,
   output logic [3:0]       dev_master_clear_out,
   output logic [3:0]       ready_held_out,
   output logic             retry_ok_out,
   output logic             mf_req_out,
   output logic             mf_we_out,
   output logic [31:0]      mf_addr_out,
   output logic [31:0]      mf_wdata_out,
   input  wire logic        mf_ack_in,
   input  wire logic [31:0] mf_rdata_in,
   io_link_if.dev           lk
);
   localparam int N = io_chan_pkg::NCH;

   typedef struct packed {
      io_chan_pkg::dev_state_type st;
      logic [N-1:0][31:0] transfer_address_pointer;
      logic [N-1:0][31:0] transfer_limit;
      logic [N-1:0] error_flag;
      logic [N-1:0] channel_interrupt_flag;
      logic [N-1:0] dmc;
      logic [N-1:0] rheld;
      logic [2:0]  pend;
      logic [2:0]  fidx;
      logic [31:0] next_block_pointer;
      logic [31:0] nxt;
      logic [31:0] bbuf;
      logic [31:0] bmf;
      logic [31:0] blen;
      logic [31:0] cbuf;
      logic [31:0] cmf;
      logic [31:0] cnt;
      logic [31:0] sca;
      logic [1:0]  cmd;
      logic [1:0]  ch;
      logic        kind;
      logic        retry;
      logic        retried;
      logic        perr;
      logic        rok;
      logic        irq;
      logic        bb_req;
      logic        bb_we;
      logic [31:0] bb_addr;
      logic [31:0] bb_wdata;
      logic        bb_wpar;
      logic        mf_req;
      logic        mf_we;
      logic [31:0] mf_addr;
      logic [31:0] mf_wdata;
      logic        ret_rdy;
      logic        cmdb_pend;
      logic [1:0]  ev_chan;
      logic        done;
      logic        ferr;
      logic        xerr;
      logic [31:0] rdata;
   } dev_reg_type;

   dev_reg_type cur;
   dev_reg_type next_cur;
   logic [2:0]  op;
   logic [1:0]  sel;
   logic [1:0]  chn;
   logic        cmdch;
   logic        to_mf;
   logic        more;
   logic        ack;
   logic        bad_par;
   logic [31:0] word;
   logic [31:0] mfa;

   always_comb
   begin
      next_cur = cur;
      next_cur.ret_rdy = 1'b0;
      next_cur.cmdb_pend = 1'b0;
      next_cur.done = 1'b0;
      next_cur.ferr = 1'b0;
      next_cur.xerr = 1'b0;
      next_cur.rdata = '0;
      op = cpu_addr_in[io_chan_pkg::CPU_AW-1:io_chan_pkg::CW];
      sel = cpu_addr_in[io_chan_pkg::CW-1:0];
      chn = cur.ch;
      cmdch = ~cur.cmd[1];
      to_mf = ~cur.cmd[0];
      more = cmdch ? (cur.transfer_address_pointer[chn] !=
                      cur.transfer_limit[chn])
                   : (cur.cnt != 32'h0);
      ack = (cur.bb_req & lk.bb_ack) | (cur.mf_req & mf_ack_in);
      bad_par = ^{lk.bb_rdata, lk.bb_rpar};
      // fetch words come from the buffer whatever the previous command was
      word = (to_mf || cur.st == io_chan_pkg::S_FETCH) ? lk.bb_rdata
                                                       : mf_rdata_in;
      mfa = cmdch ? cur.transfer_address_pointer[chn] : cur.cmf;
      if (cpu_wr_in && monitor_mode_in)
      begin
         case (op)
            io_chan_pkg::OP_SET_ADDR:
            begin
               next_cur.transfer_address_pointer[sel] = cpu_wdata_in;
               next_cur.ev_chan = sel;
               if (!sel[0])
               begin
                  next_cur.ret_rdy = 1'b1;
                  next_cur.rheld[sel] = 1'b1;
               end
               else
                  next_cur.cmdb_pend = 1'b1;
            end
            io_chan_pkg::OP_SET_LIMIT:
               next_cur.transfer_limit[sel] = cpu_wdata_in;
            io_chan_pkg::OP_CLR_INT:
            begin
               next_cur.channel_interrupt_flag[sel] = 1'b0;
               next_cur.error_flag[sel] = 1'b0;
               if (sel[0])
                  next_cur.dmc[sel] = 1'b0;
            end
            io_chan_pkg::OP_MCLR:
            begin
               next_cur.channel_interrupt_flag[sel] = 1'b0;
               next_cur.error_flag[sel] = 1'b0;
               if (sel[0])
                  next_cur.dmc[sel] = 1'b1;
               else
                  next_cur.rheld[sel] = 1'b0;
            end
            default: ;
         endcase
      end
      if (cpu_rd_in)
      begin
         case (op)
            io_chan_pkg::OP_RD_INTCH:
               // lowest numbered channel has priority
               for (int i = N - 1; i >= 0; i--)
                  if (cur.channel_interrupt_flag[i])
                  begin
                     next_cur.rdata = '0;
                     next_cur.rdata[io_chan_pkg::RD_VALID_BIT] = 1'b1;
                     next_cur.rdata[1:0] = 2'(i);
                  end
            io_chan_pkg::OP_RD_ADDR:
               next_cur.rdata = cur.transfer_address_pointer[sel];
            io_chan_pkg::OP_RD_ERR:
               next_cur.rdata = {31'h0, cur.error_flag[sel]};
            default: ;
         endcase
      end
      if (lk.blk_pending && cur.pend != io_chan_pkg::MAX_PEND)
         next_cur.pend = cur.pend + 3'h1;
      case (cur.st)
         io_chan_pkg::S_IDLE:
            if (cur.pend != 3'h0)
            begin
               next_cur.pend = next_cur.pend - 3'h1;
               next_cur.fidx = io_chan_pkg::TCB_CTRL;
               next_cur.bb_req = 1'b1;
               next_cur.bb_we = 1'b0;
               next_cur.bb_addr = cur.next_block_pointer;
               next_cur.st = io_chan_pkg::S_FETCH;
            end
         io_chan_pkg::S_FETCH:
            if (ack)
            begin
               next_cur.bb_req = 1'b0;
               if (bad_par)
               begin
                  // block is dropped; chain restarts from zero
                  next_cur.ferr = 1'b1;
                  next_cur.pend = {2'h0, lk.blk_pending};
                  next_cur.next_block_pointer = '0;
                  next_cur.st = io_chan_pkg::S_IDLE;
               end
               else
               begin
                  case (cur.fidx)
                     io_chan_pkg::TCB_CTRL:
                     begin
                        next_cur.cmd = word[io_chan_pkg::CMD_LSB+:2];
                        next_cur.retry = word[io_chan_pkg::RETRY_BIT];
                        next_cur.kind = word[io_chan_pkg::TYPE_BIT];
                        next_cur.ch = word[io_chan_pkg::CHAN_LSB+:2];
                     end
                     io_chan_pkg::TCB_BUF: next_cur.bbuf = word;
                     io_chan_pkg::TCB_MF: next_cur.bmf = word;
                     io_chan_pkg::TCB_LEN: next_cur.blen = word;
                     default: next_cur.nxt = word;
                  endcase
                  if (cur.fidx == io_chan_pkg::TCB_LAST)
                  begin
                     next_cur.retried = 1'b0;
                     next_cur.perr = 1'b0;
                     next_cur.sca = cur.transfer_address_pointer[chn];
                     next_cur.cbuf = cur.bbuf;
                     next_cur.cmf = cur.bmf;
                     next_cur.cnt = {cur.blen[31:1], 1'b0};
                     next_cur.st = io_chan_pkg::S_SRC;
                  end
                  else
                  begin
                     next_cur.fidx = cur.fidx + 3'h1;
                     next_cur.bb_req = 1'b1;
                     next_cur.bb_addr = cur.next_block_pointer +
                                        {29'h0, cur.fidx + 3'h1};
                  end
               end
            end
         io_chan_pkg::S_SRC:
            if (ack)
            begin
               next_cur.bb_req = 1'b0;
               next_cur.mf_req = 1'b0;
               if (to_mf && bad_par)
                  next_cur.perr = 1'b1;
               if (to_mf)
               begin
                  next_cur.mf_req = 1'b1;
                  next_cur.mf_we = 1'b1;
                  next_cur.mf_addr = mfa;
                  next_cur.mf_wdata = word;
               end
               else
               begin
                  next_cur.bb_req = 1'b1;
                  next_cur.bb_we = 1'b1;
                  next_cur.bb_addr = cur.cbuf;
                  next_cur.bb_wdata = word;
                  next_cur.bb_wpar = ^word;
               end
               next_cur.st = io_chan_pkg::S_DST;
            end
            else if (!more)
               next_cur.st = io_chan_pkg::S_END;
            else if (!cur.bb_req && !cur.mf_req)
            begin
               next_cur.bb_req = to_mf;
               next_cur.bb_we = 1'b0;
               next_cur.bb_addr = cur.cbuf;
               next_cur.mf_req = ~to_mf;
               next_cur.mf_we = 1'b0;
               next_cur.mf_addr = mfa;
            end
         io_chan_pkg::S_DST:
            if (ack)
            begin
               next_cur.bb_req = 1'b0;
               next_cur.mf_req = 1'b0;
               next_cur.cbuf = cur.cbuf + 32'h1;
               if (cmdch)
                  next_cur.transfer_address_pointer[chn] =
                     cur.transfer_address_pointer[chn] + 32'h1;
               else
               begin
                  next_cur.cmf = cur.cmf + 32'h1;
                  next_cur.cnt = cur.cnt - 32'h1;
               end
               next_cur.st = io_chan_pkg::S_SRC;
            end
         io_chan_pkg::S_END:
            if (cur.perr && cur.retry && !cur.retried)
            begin
               // one retry of the whole block from its start
               next_cur.retried = 1'b1;
               next_cur.perr = 1'b0;
               if (cmdch)
                  next_cur.transfer_address_pointer[chn] = cur.sca;
               next_cur.cbuf = cur.bbuf;
               next_cur.cmf = cur.bmf;
               next_cur.cnt = {cur.blen[31:1], 1'b0};
               next_cur.st = io_chan_pkg::S_SRC;
            end
            else
            begin
               next_cur.next_block_pointer = cur.nxt;
               if (cmdch)
                  next_cur.channel_interrupt_flag[chn] = 1'b1;
               if (cur.perr)
               begin
                  next_cur.xerr = 1'b1;
                  if (!cmdch)
                     next_cur.error_flag[chn] = 1'b1;
               end
               else
               begin
                  next_cur.done = 1'b1;
                  next_cur.rok = cur.rok | cur.retried;
               end
               next_cur.st = io_chan_pkg::S_IDLE;
            end
         default: next_cur.st = io_chan_pkg::S_IDLE;
      endcase
      next_cur.irq = |next_cur.channel_interrupt_flag;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cur <= '0;
         cur.st <= io_chan_pkg::S_IDLE;
      end
      else
         cur <= next_cur;
   end

   assign cpu_rdata_out = cur.rdata;
   assign cpu_io_interrupt_request_out = cur.irq;
   assign dev_master_clear_out = cur.dmc;
   assign ready_held_out = cur.rheld;
   assign retry_ok_out = cur.rok;
   assign mf_req_out = cur.mf_req;
   assign mf_we_out = cur.mf_we;
   assign mf_addr_out = cur.mf_addr;
   assign mf_wdata_out = cur.mf_wdata;
   assign lk.bb_req = cur.bb_req;
   assign lk.bb_we = cur.bb_we;
   assign lk.bb_addr = cur.bb_addr;
   assign lk.bb_wdata = cur.bb_wdata;
   assign lk.bb_wpar = cur.bb_wpar;
   assign lk.return_status_ready = cur.ret_rdy;
   assign lk.command_block_pending = cur.cmdb_pend;
   assign lk.ev_chan = cur.ev_chan;
   assign lk.blk_done = cur.done;
   assign lk.fetch_err = cur.ferr;
   assign lk.exec_err = cur.xerr;
endmodule : chan_ctrl_end

// ---- rtl/io_chan_pkg.sv ----
// shared constants and types of the channel controller and its partner
package io_chan_pkg;
   localparam int NCH = 4;
   localparam int CW = 2;
   localparam int CPU_AW = 5;
   localparam logic [2:0] OP_SET_ADDR = 3'h0;
   localparam logic [2:0] OP_SET_LIMIT = 3'h1;
   localparam logic [2:0] OP_CLR_INT = 3'h2;
   localparam logic [2:0] OP_MCLR = 3'h3;
   localparam logic [2:0] OP_RD_INTCH = 3'h4;
   localparam logic [2:0] OP_RD_ADDR = 3'h5;
   localparam logic [2:0] OP_RD_ERR = 3'h6;
   localparam int RD_VALID_BIT = 31;
   localparam logic [2:0] TCB_CTRL = 3'h0;
   localparam logic [2:0] TCB_BUF = 3'h1;
   localparam logic [2:0] TCB_MF = 3'h2;
   localparam logic [2:0] TCB_LEN = 3'h3;
   localparam logic [2:0] TCB_LAST = 3'h4;
   localparam int CMD_LSB = 0;
   localparam int RETRY_BIT = 2;
   localparam int TYPE_BIT = 3;
   localparam int CHAN_LSB = 4;
   localparam logic [2:0] MAX_PEND = 3'h7;
   localparam int MEM_AW = 5;
   localparam int MEM_D = 32;
   localparam int MUX_AW = 7;
   localparam logic [1:0] MOP_MEM = 2'h0;
   localparam logic [1:0] MOP_POST = 2'h1;
   localparam logic [1:0] MOP_STATUS = 2'h2;
   localparam logic [1:0] MOP_INJECT = 2'h3;
   localparam int ST_RET_LSB = 0;
   localparam int ST_CMDB_LSB = 4;
   localparam int ST_DONE = 8;
   localparam int ST_FERR = 9;
   localparam int ST_XERR = 10;
   localparam int ST_REFUSED = 11;
   localparam int ST_PEND_LSB = 16;
   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_FETCH = 5'b00010,
      S_SRC   = 5'b00100,
      S_DST   = 5'b01000,
      S_END   = 5'b10000
   } dev_state_type;
endpackage : io_chan_pkg

// ---- rtl/io_link_if.sv ----
// link between the channel controller and the multiplexer processor end
`timescale 1ns/1ns
interface io_link_if;
   logic        bb_req;
   logic        bb_we;
   logic [31:0] bb_addr;
   logic [31:0] bb_wdata;
   logic        bb_wpar;
   logic        bb_ack;
   logic [31:0] bb_rdata;
   logic        bb_rpar;
   logic        return_status_ready;
   logic        command_block_pending;
   logic [1:0]  ev_chan;
   logic        blk_pending;
   logic        blk_done;
   logic        fetch_err;
   logic        exec_err;
   modport dev (output bb_req, bb_we, bb_addr, bb_wdata, bb_wpar,
                return_status_ready, command_block_pending, ev_chan,
                blk_done, fetch_err, exec_err,
                input bb_ack, bb_rdata, bb_rpar, blk_pending);
   modport mux (input bb_req, bb_we, bb_addr, bb_wdata, bb_wpar,
                return_status_ready, command_block_pending, ev_chan,
                blk_done, fetch_err, exec_err,
                output bb_ack, bb_rdata, bb_rpar, blk_pending);
endinterface : io_link_if

// ---- rtl/mux_proc_end.sv ----
// multiplexer processor end: buffer memory, block posting, event status
`timescale 1ns/1ns
module mux_proc_end (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic [6:0]  user_addr_in,
   input  wire logic [31:0] user_wdata_in,
   input  wire logic        user_wr_in,
   input  wire logic        user_rd_in,
   output logic [31:0]      user_rdata_out,
   io_link_if.mux           lk
);
   typedef struct packed {
      logic [io_chan_pkg::MEM_D-1:0][31:0] mem;
      logic        ack;
      logic [31:0] rdata;
      logic        rpar;
      logic        inject;
      logic [2:0]  pend;
      logic [3:0]  ret;
      logic [3:0]  cmdb;
      logic        done;
      logic        ferr;
      logic        xerr;
      logic        refused;
      logic        blkp;
      logic [31:0] urdata;
   } mux_reg_type;

   mux_reg_type cur;
   mux_reg_type next_cur;
   logic [1:0]  op;
   logic [4:0]  idx;
   logic [4:0]  lidx;

   always_comb
   begin
      next_cur = cur;
      next_cur.ack = 1'b0;
      next_cur.blkp = 1'b0;
      next_cur.urdata = '0;
      op = user_addr_in[6:5];
      idx = user_addr_in[4:0];
      lidx = lk.bb_addr[io_chan_pkg::MEM_AW-1:0];
      if (user_wr_in)
      begin
         case (op)
            io_chan_pkg::MOP_MEM: next_cur.mem[idx] = user_wdata_in;
            io_chan_pkg::MOP_POST:
               // seven outstanding at most, pointer four-word aligned
               if (cur.pend == io_chan_pkg::MAX_PEND ||
                   user_wdata_in[1:0] != 2'h0)
                  next_cur.refused = 1'b1;
               else
               begin
                  next_cur.blkp = 1'b1;
                  next_cur.pend = cur.pend + 3'h1;
               end
            io_chan_pkg::MOP_STATUS:
            begin
               next_cur.ret = cur.ret & ~user_wdata_in[3:0];
               next_cur.cmdb = cur.cmdb & ~user_wdata_in[7:4];
               next_cur.done = cur.done & ~user_wdata_in[8];
               next_cur.ferr = cur.ferr & ~user_wdata_in[9];
               next_cur.xerr = cur.xerr & ~user_wdata_in[10];
               next_cur.refused = cur.refused & ~user_wdata_in[11];
            end
            default: ;
         endcase
      end
      if (user_rd_in)
      begin
         case (op)
            io_chan_pkg::MOP_MEM: next_cur.urdata = cur.mem[idx];
            io_chan_pkg::MOP_STATUS:
               next_cur.urdata = {13'h0, cur.pend, 4'h0, cur.refused,
                                  cur.xerr, cur.ferr, cur.done,
                                  cur.cmdb, cur.ret};
            default: ;
         endcase
      end
      // controller writes win over a user write to the same word
      if (lk.bb_req && !cur.ack)
      begin
         next_cur.ack = 1'b1;
         if (lk.bb_we)
            next_cur.mem[lidx] = lk.bb_wdata;
         else
         begin
            next_cur.rdata = cur.mem[lidx];
            next_cur.rpar = (^cur.mem[lidx]) ^ cur.inject;
            next_cur.inject = 1'b0;
         end
      end
      if (user_wr_in && op == io_chan_pkg::MOP_INJECT)
         next_cur.inject = 1'b1;
      // events set after clears so none is lost
      if (lk.return_status_ready)
         next_cur.ret[lk.ev_chan] = 1'b1;
      if (lk.command_block_pending)
         next_cur.cmdb[lk.ev_chan] = 1'b1;
      if (lk.blk_done || lk.exec_err)
      begin
         next_cur.done = next_cur.done | lk.blk_done;
         next_cur.xerr = next_cur.xerr | lk.exec_err;
         if (next_cur.pend != 3'h0)
            next_cur.pend = next_cur.pend - 3'h1;
      end
      if (lk.fetch_err)
      begin
         next_cur.ferr = 1'b1;
         next_cur.pend = 3'h0;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         cur <= '0;
      else
         cur <= next_cur;
   end

   assign lk.bb_ack = cur.ack;
   assign lk.bb_rdata = cur.rdata;
   assign lk.bb_rpar = cur.rpar;
   assign lk.blk_pending = cur.blkp;
   assign user_rdata_out = cur.urdata;
endmodule : mux_proc_end

// ---- test/io_link_monitor.sv ----
// link checks between the controller end and the multiplexer end
`timescale 1ns/1ns
module io_link_monitor (
   input wire logic        clk_sys_in,
   input wire logic        rst_in,
   input wire logic        bb_req,
   input wire logic        bb_we,
   input wire logic [31:0] bb_addr,
   input wire logic [31:0] bb_wdata,
   input wire logic        bb_wpar,
   input wire logic        bb_ack,
   input wire logic        return_status_ready,
   input wire logic        command_block_pending,
   input wire logic [1:0]  ev_chan,
   input wire logic        blk_done,
   input wire logic        fetch_err
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   // answer next cycle, one cycle long; fetch may keep the request up
   sequence s_answer;
      ##1 bb_ack ##1 !bb_ack;
   endsequence
   sequence s_hold;
      bb_req && $stable(bb_addr) && $stable(bb_we);
   endsequence
   chk_req_answer: assert property ($rose(bb_req) |-> s_answer)
      else $error("link answer out of step");
   chk_req_held: assert property (bb_req && !bb_ack |=> s_hold)
      else $error("link request moved before answer");
   chk_ack_with_req: assert property (bb_ack |-> bb_req)
      else $error("link answer without request");
   chk_write_parity: assert property
      (bb_req && bb_we |-> !(^{bb_wdata, bb_wpar}))
      else $error("odd parity on write word");
   chk_status_even: assert property
      (return_status_ready |-> !ev_chan[0])
      else $error("status ready on output channel");
   chk_status_pulse: assert property
      (return_status_ready |=> !return_status_ready)
      else $error("status ready longer than one cycle");
   chk_pending_odd: assert property
      (command_block_pending |-> ev_chan[0] ##1 !command_block_pending)
      else $error("command pending on wrong channel");
   chk_fetch_no_done: assert property (fetch_err |-> !blk_done)
      else $error("block done beside fetch error");
endmodule : io_link_monitor

// ---- test/tb_io_channel_transfer_control.sv ----
// self-checking bench for both ends of the channel link
`timescale 1ns/1ns
module tb_io_channel_transfer_control;
   logic        clk = 0, rst = 1, mon = 0, cw = 0, cr = 0;
   logic        uw = 0, ur = 0, ack = 0, irq, rok, req, we;
   logic [4:0]  ca = '0;
   logic [6:0]  ua = '0;
   logic [3:0]  dmc, rh;
   logic [31:0] cd = '0, ud = '0, mrd = '0, crd, urd, rv, s, ma, mwd, k;
   logic [31:0] mfm [32];
   logic [31:0] d [4];
   int          err_count = 0, total_checks = 0;
   io_link_if lk ();
   chan_ctrl_end chan_ctrl_end_inst (.clk_sys_in(clk), .rst_in(rst),
      .monitor_mode_in(mon), .cpu_addr_in(ca), .cpu_wdata_in(cd),
      .cpu_wr_in(cw), .cpu_rd_in(cr), .cpu_rdata_out(crd),
      .cpu_io_interrupt_request_out(irq), .dev_master_clear_out(dmc),
      .ready_held_out(rh), .retry_ok_out(rok), .mf_req_out(req),
      .mf_we_out(we), .mf_addr_out(ma), .mf_wdata_out(mwd),
      .mf_ack_in(ack), .mf_rdata_in(mrd), .lk(lk));
   mux_proc_end mux_proc_end_inst (.clk_sys_in(clk), .rst_in(rst),
      .user_addr_in(ua), .user_wdata_in(ud), .user_wr_in(uw),
      .user_rd_in(ur), .user_rdata_out(urd), .lk(lk));
   io_link_monitor io_link_monitor_inst (.clk_sys_in(clk), .rst_in(rst),
      .bb_req(lk.bb_req), .bb_we(lk.bb_we), .bb_addr(lk.bb_addr),
      .bb_wdata(lk.bb_wdata), .bb_wpar(lk.bb_wpar), .bb_ack(lk.bb_ack),
      .return_status_ready(lk.return_status_ready),
      .command_block_pending(lk.command_block_pending),
      .ev_chan(lk.ev_chan), .blk_done(lk.blk_done),
      .fetch_err(lk.fetch_err));
   initial
   begin
      forever #4 clk = !clk;
   end
   // mainframe memory: one-cycle answer, read data scrambled when idle
   always @(posedge clk)
   begin
      ack <= req && !ack;
      mrd <= (req && !ack) ? mfm[ma[4:0]] : ~mrd;
      if (req && !ack && we)
         mfm[ma[4:0]] <= mwd;
   end
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs
   function automatic logic [31:0] w0(input logic [1:0] c,
                                      input logic [1:0] ch);
      return {26'h0, ch, 2'h0, c};
   endfunction : w0
   task chk(input string n, input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      err_count += (g !== e);
      if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
   endtask : chk
   task cpu(input logic w, input logic [2:0] op, input logic [1:0] ch,
            input logic [31:0] v);
      @(posedge clk);
      {cw, cr, ca, cd} <= {w, !w, op, ch, v};
      @(posedge clk);
      {cw, cr} <= 2'h0;
      #1 rv = crd;
   endtask : cpu
   task mux(input logic w, input logic [1:0] op, input logic [4:0] ix,
            input logic [31:0] v);
      @(posedge clk);
      {uw, ur, ua, ud} <= {w, !w, op, ix, v};
      @(posedge clk);
      {uw, ur} <= 2'h0;
      #1 rv = urd;
   endtask : mux
   task tcb(input logic [4:0] b, input logic [31:0] w [5]);
      for (int i = 0; i < 5; i++) mux(1'b1, 2'h0, b + 5'(i), w[i]);
   endtask : tcb
   // clear status first so a fast event is never wiped by the clear
   task automatic run(input logic [4:0] b, input int bn,
                      input int dly = 0);
      int n = 0;
      mux(1'b1, 2'h2, 5'h0, 32'hffff_ffff);
      mux(1'b1, 2'h1, 5'h0, {27'h0, b});
      if (dly > 0)
      begin
         repeat (dly) @(posedge clk);
         mux(1'b1, 2'h3, 5'h0, 32'h0);
      end
      do mux(1'b0, 2'h2, 5'h0, 32'h0); while (rv[bn] !== 1'b1 && ++n < 300);
      chk("status event", 32'(rv[bn]), 32'h1);
   endtask : run
   task stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      stop_test();
   end
   initial
   begin
      s = 32'h0000_1e99;
      for (int i = 0; i < 32; i++) mfm[i] = xs();
      repeat (20) @(posedge clk);
      rst <= 0;
      cpu(1'b1, io_chan_pkg::OP_SET_ADDR, 2'h0, 32'h5);
      cpu(1'b0, io_chan_pkg::OP_RD_ADDR, 2'h0, 32'h0);
      chk("user mode write", rv, 32'h0);
      mon <= 1;
      cpu(1'b1, io_chan_pkg::OP_SET_LIMIT, 2'h0, 32'h8);
      cpu(1'b1, io_chan_pkg::OP_SET_ADDR, 2'h0, 32'h4);
      cpu(1'b0, io_chan_pkg::OP_RD_ADDR, 2'h0, 32'h0);
      chk("pointer load", rv, 32'h4);
      chk("ready held", 32'(rh[0]), 32'h1);
      mux(1'b0, 2'h2, 5'h0, 32'h0);
      chk("status ready", 32'(rv[0]), 32'h1);
      $display("test channel open done");
      for (int i = 0; i < 4; i++) d[i] = xs();
      for (int i = 0; i < 4; i++) mux(1'b1, 2'h0, 5'(8 + i), d[i]);
      k = mfm[8];
      tcb(5'h0, '{w0(2'h0, 2'h0), 32'h8, xs(), xs(), 32'h10});
      run(5'h0, 8);
      for (int i = 0; i < 4; i++) chk("mf word", mfm[4 + i], d[i]);
      chk("limit word", mfm[8], k);
      cpu(1'b0, io_chan_pkg::OP_RD_ADDR, 2'h0, 32'h0);
      chk("pointer end", rv, 32'h8);
      chk("cpu irq", 32'(irq), 32'h1);
      cpu(1'b0, io_chan_pkg::OP_RD_INTCH, 2'h0, 32'h0);
      chk("int channel", rv, 32'h8000_0000);
      $display("test command block done");
      cpu(1'b1, io_chan_pkg::OP_SET_LIMIT, 2'h1, 32'hc);
      cpu(1'b1, io_chan_pkg::OP_SET_ADDR, 2'h1, 32'ha);
      mux(1'b0, 2'h2, 5'h0, 32'h0);
      chk("cmd pending", 32'(rv[5]), 32'h1);
      cpu(1'b1, io_chan_pkg::OP_MCLR, 2'h1, 32'h0);
      chk("dev clear set", 32'(dmc[1]), 32'h1);
      cpu(1'b1, io_chan_pkg::OP_CLR_INT, 2'h1, 32'h0);
      chk("dev clear off", 32'(dmc[1]), 32'h0);
      cpu(1'b1, io_chan_pkg::OP_MCLR, 2'h0, 32'h0);
      chk("held cleared", {27'h0, irq, rh}, 32'h0);
      cpu(1'b0, io_chan_pkg::OP_RD_ERR, 2'h0, 32'h0);
      chk("error flag", rv, 32'h0);
      $display("test clear ops done");
      k = xs();
      mux(1'b1, 2'h0, 5'd26, k);
      tcb(5'h10, '{w0(2'h3, 2'h1), 32'd24, 32'h0, 32'h3, 32'h0});
      run(5'h10, 8);
      for (int i = 0; i < 3; i++)
      begin
         mux(1'b0, 2'h0, 5'(24 + i), 32'h0);
         chk("buf word", rv, (i < 2) ? mfm[i] : k);
      end
      $display("test data block done");
      k = mfm[0];
      tcb(5'h0, '{w0(2'h2, 2'h0), 32'd28, 32'h0, 32'h0, 32'h0});
      mux(1'b1, 2'h3, 5'h0, 32'h0);
      run(5'h0, 9);
      chk("queue empty", 32'(rv[18:16]), 32'h0);
      run(5'h0, 8);
      chk("no data moved", mfm[0], k);
      $display("test fetch error done");
      tcb(5'h0, '{w0(2'h2, 2'h0) | 32'h4, 32'h8, 32'hc, 32'h4, 32'h0});
      // fault lands after the fetch, on an execution read
      run(5'h0, 8, 12);
      chk("retry ok", 32'(rok), 32'h1);
      for (int i = 0; i < 4; i++) chk("retry word", mfm[12 + i], d[i]);
      $display("test retry done");
      stop_test();
   end
endmodule : tb_io_channel_transfer_control
